// File: eam_exclusive_access_monitor.sv
// file: exclusive load/store/clear sequencing against a shared memory system
// Behaviour
// - exclusive loads read and record access
// - store status 0 if stored, 1 otherwise
// - status 0 only without foreign access
// - after clear, next store fails, no write
// - word address is base plus offset
// - exclusive accesses never touch condition flags
module eam_exclusive_access_monitor
  import eam_pkg::*;
(
  input  wire logic              clk_in,          // processor clock, 125 MHz
  input  wire logic              resetn_in,       // async reset, active low
  input  wire eam_req_t          req_in,          // request, op not NONE = valid
  output eam_rsp_t               rsp_out,         // registered answer
  output logic                   busy_out,        // request in flight, hold req
  output eam_mem_req_t           mem_req_out,     // registered memory request
  input  wire logic              mem_ack_in,      // memory done (same clock)
  input  wire logic [EAM_DW-1:0] mem_rdata_in,    // memory read data
  input  wire logic              snoop_valid_in,  // other master wrote memory
  input  wire logic [EAM_AW-1:0] snoop_addr_in,   // address it wrote
  output logic                   flags_we_out     // condition flag write enable
);

  // sequencer states
  typedef enum logic [1:0] {
    EAM_ST_IDLE,
    EAM_ST_LOAD,
    EAM_ST_STORE
  } eam_state_t;

  eam_state_t        state_reg;   // current state
  logic [EAM_AW-1:0] addr_eff;    // effective address of request
  logic              accept;      // request taken this cycle
  logic              is_load;     // decoded load
  logic              is_store;    // decoded store
  logic              is_clear;    // decoded clear
  logic              store_ok;    // store may go to memory
  logic              mon_open;    // reservation held
  logic              mon_match;   // address and size agree
  logic              mon_snoop;   // foreign access hit
  logic              mon_set;     // record reservation
  logic              mon_clr;     // drop reservation

  // effective address; offset only applies to word accesses
  function automatic logic [EAM_AW-1:0] eff_addr(input eam_req_t r);
    logic [EAM_AW-1:0] ofs;
    ofs = '0;
    if (r.size == EAM_SZ_WORD) begin
      ofs = EAM_AW'({r.offset_words, 2'h0});
    end
    return r.base_address_reg + ofs;
  endfunction

  assign addr_eff = eff_addr(req_in);
  assign accept   = (state_reg == EAM_ST_IDLE) && (req_in.op != EAM_OP_NONE);
  assign is_load  = accept && (req_in.op == EAM_OP_LOAD_EXCL);
  assign is_store = accept && (req_in.op == EAM_OP_STORE_EXCL);
  assign is_clear = accept && (req_in.op == EAM_OP_CLEAR_EXCL_MONITOR);
  // a snoop in the acceptance cycle already spoils the store
  assign store_ok = mon_match && !(snoop_valid_in && mon_snoop);
  assign mon_set  = is_load;
  // any store attempt or clear drops the reservation; so does a foreign write
  assign mon_clr  = is_store || is_clear || (snoop_valid_in && mon_snoop);

  eam_monitor_entry u_entry (
    .clk_in        (clk_in),
    .resetn_in     (resetn_in),
    .set_in        (mon_set),
    .clr_in        (mon_clr),
    .addr_in       (addr_eff),
    .size_in       (req_in.size),
    .cmp_addr_in   (addr_eff),
    .cmp_size_in   (req_in.size),
    .snoop_addr_in (snoop_addr_in),
    .open_out      (mon_open),
    .match_out     (mon_match),
    .snoop_hit_out (mon_snoop)
  );

  // sequencer: idle -> load or store -> idle on memory ack
  always_ff @(posedge clk_in or negedge resetn_in) begin
    if (!resetn_in) begin
      state_reg <= EAM_ST_IDLE;
    end else begin
      case (state_reg)
        EAM_ST_IDLE: begin
          if (is_load) begin
            state_reg <= EAM_ST_LOAD;
          end else if (is_store && store_ok) begin
            state_reg <= EAM_ST_STORE;
          end
        end
        EAM_ST_LOAD, EAM_ST_STORE: begin
          if (mem_ack_in) begin
            state_reg <= EAM_ST_IDLE;
          end
        end
        default: begin
          state_reg <= EAM_ST_IDLE;
        end
      endcase
    end
  end

  // busy mirrors the in-flight memory access
  always_ff @(posedge clk_in or negedge resetn_in) begin
    if (!resetn_in) begin
      busy_out <= 1'h0;
    end else if (is_load || (is_store && store_ok)) begin
      busy_out <= 1'h1;
    end else if (mem_ack_in) begin
      busy_out <= 1'h0;
    end
  end

  // memory request held until acknowledged; failed store never writes
  always_ff @(posedge clk_in or negedge resetn_in) begin
    if (!resetn_in) begin
      mem_req_out <= '0;
    end else if (is_load) begin
      mem_req_out <= '{valid: 1'h1, write: 1'h0, size: req_in.size,
                       addr: addr_eff, wdata: '0};
    end else if (is_store && store_ok) begin
      mem_req_out <= '{valid: 1'h1, write: 1'h1, size: req_in.size,
                       addr: addr_eff, wdata: req_in.data_transfer_reg};
    end else if (mem_ack_in) begin
      mem_req_out.valid <= 1'h0;
    end
  end

  // answer: failed store and clear answer at once, others on ack
  always_ff @(posedge clk_in or negedge resetn_in) begin
    if (!resetn_in) begin
      rsp_out <= '0;
    end else begin
      rsp_out.done <= 1'h0;
      if (is_store && !store_ok) begin
        rsp_out.done     <= 1'h1;
        rsp_out.is_store <= 1'h1;
        rsp_out.status   <= EAM_STAT_FAIL;
      end else if (is_clear) begin
        rsp_out.done     <= 1'h1;
        rsp_out.is_store <= 1'h0;
        rsp_out.status   <= EAM_STAT_OK;
      end else if (mem_ack_in && state_reg == EAM_ST_STORE) begin
        rsp_out.done     <= 1'h1;
        rsp_out.is_store <= 1'h1;
        rsp_out.status   <= EAM_STAT_OK;
      end else if (mem_ack_in && state_reg == EAM_ST_LOAD) begin
        rsp_out.done      <= 1'h1;
        rsp_out.is_store  <= 1'h0;
        rsp_out.status    <= EAM_STAT_OK;
        rsp_out.load_data <= mem_rdata_in;
      end
    end
  end

  // condition flags are never written by these operations
  always_ff @(posedge clk_in or negedge resetn_in) begin
    if (!resetn_in) begin
      flags_we_out <= 1'h0;
    end else begin
      flags_we_out <= 1'h0;
    end
  end

  // checks
  property p_fail_no_write;
    @(posedge clk_in) disable iff (!resetn_in)
      (is_store && !store_ok) |=> (rsp_out.done && rsp_out.status && !mem_req_out.valid);
  endproperty
  // the write bit keeps the last request's value, so the strobe is what must stay low
  a_fail_no_write: assert property (p_fail_no_write) else $error("failed store wrote");

  property p_ok_status;
    @(posedge clk_in) disable iff (!resetn_in)
      (state_reg == EAM_ST_STORE && mem_ack_in) |=> (rsp_out.done && !rsp_out.status);
  endproperty
  a_ok_status: assert property (p_ok_status) else $error("store status not zero");

  property p_clear_then_fail;
    @(posedge clk_in) disable iff (!resetn_in)
      is_clear |=> !mon_open;
  endproperty
  a_clear_then_fail: assert property (p_clear_then_fail) else $error("clear left entry");

  property p_snoop_kills;
    @(posedge clk_in) disable iff (!resetn_in)
      (snoop_valid_in && mon_snoop && !is_load) |=> !mon_open;
  endproperty
  a_snoop_kills: assert property (p_snoop_kills) else $error("snoop kept entry");

  property p_load_records;
    @(posedge clk_in) disable iff (!resetn_in)
      is_load |=> (mon_open && mem_req_out.valid && !mem_req_out.write);
  endproperty
  a_load_records: assert property (p_load_records) else $error("load not recorded");

  property p_word_addr;
    @(posedge clk_in) disable iff (!resetn_in)
      (is_load && req_in.size == EAM_SZ_WORD) |=>
        (mem_req_out.addr ==
         $past(req_in.base_address_reg) + EAM_AW'({$past(req_in.offset_words), 2'h0}));
  endproperty
  a_word_addr: assert property (p_word_addr) else $error("bad word address");

  property p_no_flags;
    @(posedge clk_in) disable iff (!resetn_in)
      $rose(rsp_out.done) |-> !flags_we_out;
  endproperty
  a_no_flags: assert property (p_no_flags) else $error("flags written");

  property p_store_clears;
    @(posedge clk_in) disable iff (!resetn_in)
      is_store |=> !mon_open;
  endproperty
  a_store_clears: assert property (p_store_clears) else $error("store left entry");

endmodule

// File: eam_mem_model.sv
// file: behavioural shared memory that answers the monitor's memory requests
module eam_mem_model
  import eam_pkg::*;
(
  input  wire logic         clk_in,        // processor clock
  input  wire logic         resetn_in,     // async reset, active low
  input  wire eam_mem_req_t mem_req_in,    // request from the monitor
  input  wire logic [1:0]   delay_in,      // extra wait cycles before ack
  output logic              mem_ack_out,   // one-cycle completion pulse
  output logic [EAM_DW-1:0] mem_rdata_out  // read data, valid with ack only
);
  logic [1:0] wait_reg;  // cycles already waited on this request

  // contents are a fixed pattern of the word address, so no storage is needed
  always @(posedge clk_in or negedge resetn_in) begin
    if (!resetn_in) begin
      wait_reg      <= 2'h0;
      mem_ack_out   <= 1'b0;
      mem_rdata_out <= 32'h0;
    end else if (mem_ack_out || !mem_req_in.valid) begin
      // bus released: data toggles so a stale word never passes for a fresh one
      wait_reg      <= 2'h0;
      mem_ack_out   <= 1'b0;
      mem_rdata_out <= ~mem_rdata_out;
    end else if (wait_reg >= delay_in) begin
      mem_ack_out   <= 1'b1;
      mem_rdata_out <= {mem_req_in.addr[31:2], 2'h0} ^ 32'hc3a5_96e1;
    end else begin
      wait_reg <= wait_reg + 2'h1;  // slow answer
    end
  end
endmodule

// File: eam_monitor_entry.sv
// file: single exclusive monitor entry (address and size tag)
module eam_monitor_entry
  import eam_pkg::*;
(
  input  wire logic              clk_in,        // processor clock
  input  wire logic              resetn_in,     // async reset, active low
  input  wire logic              set_in,        // exclusive load records entry
  input  wire logic              clr_in,        // store attempt, clear or snoop
  input  wire logic [EAM_AW-1:0] addr_in,       // address to record
  input  wire eam_size_t         size_in,       // size to record
  input  wire logic [EAM_AW-1:0] cmp_addr_in,   // address to compare
  input  wire eam_size_t         cmp_size_in,   // size to compare
  input  wire logic [EAM_AW-1:0] snoop_addr_in, // address touched by others
  output logic                   open_out,      // entry holds a reservation
  output logic                   match_out,     // compare hits open entry
  output logic                   snoop_hit_out  // another agent touched entry
);

  logic              valid_reg;  // reservation held
  logic [EAM_AW-1:0] addr_reg;   // reserved address
  eam_size_t         size_reg;   // reserved size

  // set wins over clear so a load in the same cycle as a snoop still records
  always_ff @(posedge clk_in or negedge resetn_in) begin
    if (!resetn_in) begin
      valid_reg <= EAM_MON_RST;
    end else if (set_in) begin
      valid_reg <= 1'h1;
    end else if (clr_in) begin
      valid_reg <= 1'h0;
    end
  end

  // tag captured only on a load
  always_ff @(posedge clk_in or negedge resetn_in) begin
    if (!resetn_in) begin
      addr_reg <= '0;
      size_reg <= EAM_SZ_WORD;
    end else if (set_in) begin
      addr_reg <= addr_in;
      size_reg <= size_in;
    end
  end

  // word-granular snoop compare: conservative, may fail a store needlessly
  assign open_out      = valid_reg;
  assign match_out     = valid_reg && (addr_reg == cmp_addr_in) && (size_reg == cmp_size_in);
  assign snoop_hit_out = valid_reg && (addr_reg[EAM_AW-1:2] == snoop_addr_in[EAM_AW-1:2]);

endmodule

// File: eam_pkg.sv
// package: types and constants for the exclusive access monitor
package eam_pkg;

  localparam int unsigned EAM_AW          = 32;     // address width
  localparam int unsigned EAM_DW          = 32;     // data width
  localparam int unsigned EAM_OFS_W       = 8;      // offset field, in words
  localparam int unsigned EAM_OFS_SHIFT   = 2;      // offset counts words
  localparam logic        EAM_STAT_OK     = 1'h0;   // store carried out
  localparam logic        EAM_STAT_FAIL   = 1'h1;   // store not carried out
  localparam logic        EAM_MON_RST     = 1'h0;   // monitor empty after reset

  // operation requested by the instruction stream
  typedef enum logic [2:0] {
    EAM_OP_LOAD_EXCL,
    EAM_OP_STORE_EXCL,
    EAM_OP_CLEAR_EXCL_MONITOR,
    EAM_OP_NONE
  } eam_op_t;

  // access size of an exclusive access
  typedef enum logic [1:0] {
    EAM_SZ_BYTE,
    EAM_SZ_HALF,
    EAM_SZ_WORD
  } eam_size_t;

  // request from the instruction stream
  typedef struct packed {
    eam_op_t              op;                 // kind of operation
    eam_size_t            size;               // byte, half or word
    logic [EAM_AW-1:0]    base_address_reg;   // base register value
    logic [EAM_OFS_W-1:0] offset_words;       // immediate offset / 4 (word only)
    logic [EAM_DW-1:0]    data_transfer_reg;  // store data
  } eam_req_t;

  // answer to the instruction stream
  typedef struct packed {
    logic              done;          // one-cycle completion pulse
    logic              is_store;      // answer belongs to an exclusive store
    logic              status;        // store status: 0 ok, 1 failed
    logic [EAM_DW-1:0] load_data;     // value for the target register
  } eam_rsp_t;

  // memory request toward the shared memory system
  typedef struct packed {
    logic              valid;         // request strobe
    logic              write;         // 1 write, 0 read
    eam_size_t         size;          // access size
    logic [EAM_AW-1:0] addr;          // byte address
    logic [EAM_DW-1:0] wdata;         // write data
  } eam_mem_req_t;

endpackage

// File: tb_exclusive_access_monitor.sv
// file: self-checking testbench of the exclusive access monitor
module tb_exclusive_access_monitor;
  timeunit 1ns;
  timeprecision 1ps;
  import eam_pkg::*;

  logic         clk_in;          // processor clock
  logic         resetn_in;       // reset, active low
  eam_req_t     req_in;          // instruction stream request
  eam_rsp_t     rsp_out;         // answer
  logic         busy_out;        // request in flight
  eam_mem_req_t mem_req_out;     // memory request
  logic         mem_ack_in;      // memory completion
  logic [31:0]  mem_rdata_in;    // memory read data
  logic         snoop_valid_in;  // other master access
  logic [31:0]  snoop_addr_in;   // its address
  logic         flags_we_out;    // condition flag write
  logic [1:0]   delay_reg;       // memory wait chosen per operation
  int           err_count;       // mismatches
  int           n_tests;         // comparisons
  int           seed;            // random seed
  logic         mon_open;        // expected entry state
  logic [31:0]  mon_addr;        // expected recorded address
  eam_size_t    mon_size;        // expected recorded size
  logic         snoop_now;       // foreign access in the next request's cycle

  eam_exclusive_access_monitor dut_u (.clk_in(clk_in), .resetn_in(resetn_in), .req_in(req_in),
    .rsp_out(rsp_out), .busy_out(busy_out), .mem_req_out(mem_req_out), .mem_ack_in(mem_ack_in),
    .mem_rdata_in(mem_rdata_in), .snoop_valid_in(snoop_valid_in), .snoop_addr_in(snoop_addr_in),
    .flags_we_out(flags_we_out));
  eam_mem_model mem_u (.clk_in(clk_in), .resetn_in(resetn_in), .mem_req_in(mem_req_out),
    .delay_in(delay_reg), .mem_ack_out(mem_ack_in), .mem_rdata_out(mem_rdata_in));

  // clock generator, 8 ns period
  initial begin
    clk_in = 1'b0;
    forever #4 clk_in = ~clk_in;
  end

  // compare one value, report and count a mismatch
  task automatic check(input logic [63:0] seen, input logic [63:0] exp);
    n_tests++;
    if (seen !== exp) begin
      err_count++;
      $display("[FAIL] t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask

  // word contents of the memory model, worked out independently
  function automatic logic [31:0] pat(input logic [31:0] a);
    return {a[31:2], 2'h0} ^ 32'hc3a5_96e1;
  endfunction

  // one request, then wait for its answer; memory traffic is watched meanwhile
  task automatic run_op(input eam_op_t op, input eam_size_t sz, input logic [31:0] base,
                        input logic [7:0] ofs, input logic [31:0] dat);
    logic [31:0] a;
    logic        hit;
    logic        saw;
    a   = (sz == EAM_SZ_WORD) ? base + {22'h0, ofs, 2'h0} : base;
    // a foreign access to the word in the store's own cycle spoils it
    hit = mon_open && (mon_addr == a) && (mon_size == sz) && !snoop_now;
    saw = 1'b0;
    @(posedge clk_in);
    // status comes back in its own field, apart from the data and base operands
    req_in    <= '{op, sz, base, ofs, dat};
    delay_reg <= 2'($random(seed));
    snoop_valid_in <= snoop_now;
    snoop_addr_in  <= a;
    @(posedge clk_in);
    req_in.op <= EAM_OP_NONE;
    snoop_valid_in <= 1'b0;
    for (int i = 0; i < 40; i++) begin
      #1;
      if (mem_req_out.valid && !saw) begin
        saw = 1'b1;
        check(mem_req_out.write, op == EAM_OP_STORE_EXCL);
        check(mem_req_out.addr, a);
        check(mem_req_out.size, sz);
        check(busy_out, 1'b1);
        if (op == EAM_OP_STORE_EXCL) check(mem_req_out.wdata, dat);
      end
      if (rsp_out.done === 1'b1) break;
      @(posedge clk_in);
    end
    check(rsp_out.done, 1'b1);
    check(busy_out, 1'b0);
    check(saw, op == EAM_OP_LOAD_EXCL || (op == EAM_OP_STORE_EXCL && hit));
    check(rsp_out.is_store, op == EAM_OP_STORE_EXCL);
    if (op == EAM_OP_STORE_EXCL) begin
      check(rsp_out.status, hit ? EAM_STAT_OK : EAM_STAT_FAIL);
    end
    if (op == EAM_OP_LOAD_EXCL && sz == EAM_SZ_WORD) check(rsp_out.load_data, pat(a));
    check(flags_we_out, 1'b0);
    // any store attempt or clear empties the single entry
    mon_open = (op == EAM_OP_LOAD_EXCL);
    mon_addr = a;
    mon_size = sz;
  endtask

  // another master touches a word while the monitor is idle
  task automatic snoop(input logic [31:0] a);
    @(posedge clk_in);
    snoop_valid_in <= 1'b1;
    snoop_addr_in  <= a;
    @(posedge clk_in);
    snoop_valid_in <= 1'b0;
    snoop_addr_in  <= ~a;
    if (a[31:2] == mon_addr[31:2]) mon_open = 1'b0;
  endtask

  // verdict, printed from one place only
  task automatic tally_and_finish();
    $display("comparisons %0d mismatches %0d", n_tests, err_count);
    if (err_count == 0 && n_tests > 0) begin
      $display("*** PASS ***");
    end else begin
      $display("*** FAIL ***");
    end
    $finish;
  endtask

  // watchdog: far beyond the few thousand cycles the tests need
  initial begin
    repeat (60000) @(posedge clk_in);
    err_count++;
    tally_and_finish();
  end

  // main sequence
  initial begin
    logic [31:0] b;
    logic [7:0]  o;
    eam_size_t   s;
    int          k;
    seed = 32'hd64159f6;
    err_count = 0;
    n_tests = 0;
    resetn_in = 1'b0;
    req_in = '{EAM_OP_NONE, EAM_SZ_WORD, 32'h0, 8'h0, 32'h0};
    snoop_valid_in = 1'b0;
    snoop_addr_in = 32'h0;
    delay_reg = 2'h0;
    snoop_now = 1'b0;
    mon_open = 1'b0;
    mon_addr = 32'h0;
    mon_size = EAM_SZ_WORD;
    repeat (16) @(posedge clk_in);
    check({rsp_out.done, busy_out, mem_req_out.valid}, 3'h0);
    resetn_in <= 1'b1;
    // each size: matched pair succeeds, repeat store fails (software pairs them)
    for (int z = 0; z < 3; z++) begin
      run_op(EAM_OP_LOAD_EXCL, eam_size_t'(z), 32'h200 + z, 8'hff, 32'h0);
      run_op(EAM_OP_STORE_EXCL, eam_size_t'(z), 32'h200 + z, 8'hff, 32'ha5a5_0001);
      run_op(EAM_OP_STORE_EXCL, eam_size_t'(z), 32'h200 + z, 8'hff, 32'h1);
    end
    run_op(EAM_OP_LOAD_EXCL, EAM_SZ_HALF, 32'h312, 8'h0, 32'h0);
    run_op(EAM_OP_CLEAR_EXCL_MONITOR, EAM_SZ_HALF, 32'h312, 8'h0, 32'h0);
    run_op(EAM_OP_STORE_EXCL, EAM_SZ_HALF, 32'h312, 8'h0, 32'h7);
    run_op(EAM_OP_LOAD_EXCL, EAM_SZ_WORD, 32'h400, 8'h1, 32'h0);
    snoop(32'h407);
    run_op(EAM_OP_STORE_EXCL, EAM_SZ_WORD, 32'h400, 8'h1, 32'h9);
    run_op(EAM_OP_LOAD_EXCL, EAM_SZ_BYTE, 32'h500, 8'h0, 32'h0);
    run_op(EAM_OP_STORE_EXCL, EAM_SZ_HALF, 32'h500, 8'h0, 32'h3);
    run_op(EAM_OP_LOAD_EXCL, EAM_SZ_WORD, 32'h600, 8'h0, 32'h0);
    snoop(32'h604);
    run_op(EAM_OP_STORE_EXCL, EAM_SZ_WORD, 32'h600, 8'h1, 32'h4);
    // snoop with the load still records; snoop with the store spoils it
    snoop_now = 1'b1;
    run_op(EAM_OP_LOAD_EXCL, EAM_SZ_WORD, 32'h700, 8'h2, 32'h0);
    snoop_now = 1'b0;
    run_op(EAM_OP_STORE_EXCL, EAM_SZ_WORD, 32'h700, 8'h2, 32'h11);
    run_op(EAM_OP_LOAD_EXCL, EAM_SZ_WORD, 32'h700, 8'h2, 32'h0);
    snoop_now = 1'b1;
    run_op(EAM_OP_STORE_EXCL, EAM_SZ_WORD, 32'h700, 8'h2, 32'h12);
    snoop_now = 1'b0;
    // a reset in mid-run drops an open reservation, so the next store fails
    run_op(EAM_OP_LOAD_EXCL, EAM_SZ_WORD, 32'h900, 8'h0, 32'h0);
    @(posedge clk_in);
    resetn_in <= 1'b0;
    repeat (2) @(posedge clk_in);
    check({rsp_out.done, busy_out, mem_req_out.valid}, 3'h0);
    resetn_in <= 1'b1;
    mon_open = 1'b0;
    run_op(EAM_OP_STORE_EXCL, EAM_SZ_WORD, 32'h900, 8'h0, 32'h5);
    // random mix; stores mostly reuse the last load's operands, gap kept short
    for (int n = 0; n < 300; n++) begin
      k = $random(seed) & 15;
      if (k < 5 || !mon_open) begin
        b = 32'h800 + (($random(seed) & 7) << 2) + (($random(seed) & 1) ? 32'h2 : 32'h0);
        o = ($random(seed) & 1) ? 8'hff : 8'(($random(seed) & 3));
        s = eam_size_t'(($random(seed) & 1) ? 2 : ($random(seed) & 1));
      end
      if (k < 4) run_op(EAM_OP_LOAD_EXCL, s, b, o, 32'h0);
      else if (k < 12) run_op(EAM_OP_STORE_EXCL, s, b, o, $random(seed));
      else if (k < 13) run_op(EAM_OP_CLEAR_EXCL_MONITOR, s, b, o, 32'h0);
      else snoop(($random(seed) & 1) ? mon_addr : 32'h800 + (($random(seed) & 7) << 2));
    end
    tally_and_finish();
  end
endmodule
